/* hdl/sldc_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sldc_top (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire logic             debug_req_n_i,
  output logic                  debug_req_n_o,
  output logic                  debug_req_oe_n_o,
  input  wire logic             core_debug_mode_i,
  input  wire logic             tile_debug_event_i,
  output logic                  debug_call_trap_o,
  input  wire logic [7:0][1:0]  ext_route_type_i,
  input  wire logic [7:0][7:0]  ext_route_dest_i,
  input  wire logic [7:0]       ext_junk_i,
  input  wire logic [7:0]       ext_route_out_i,
  input  wire logic [7:0]       ext_route_in_i,
  input  wire logic [3:0][1:0]  proc_route_type_i,
  input  wire logic [3:0][7:0]  proc_route_dest_i,
  input  wire logic [3:0]       proc_junk_i,
  input  wire logic [3:0]       proc_route_out_i,
  input  wire logic [3:0]       proc_route_in_i,
  output logic      [7:0][3:0]  ext_direction_o,
  output logic      [7:0][1:0]  ext_network_o,
  output logic      [3:0][1:0]  proc_network_o,
  input  wire logic [7:0]       link_error_i,
  input  wire logic [7:0]       link_credit_granted_i,
  input  wire logic [7:0]       link_credit_held_i,
  output logic      [7:0]       link_enable_o,
  output logic      [7:0]       link_wide_o,
  output logic      [7:0]       link_link_greeting_token_o,
  output logic      [7:0]       link_rx_reset_o,
  output logic      [7:0][10:0] link_transition_gap_o,
  output logic      [7:0][10:0] link_token_gap_o
);
  typedef struct packed {
    logic [31:0]     rdata;
    logic [7:0][3:0] dir;
    logic [7:0][1:0] ext_net;
    logic [3:0][1:0] proc_net;
  } sldc_top_type;
  sldc_top_type     s_ff, nxt_s;
  sldc_bus_if       bus ();
  logic [9:0]       idx;
  logic [2:0]       slot;
  logic [1:0]       pslot;
  logic             hit_dcfg;
  logic             hit_dsrc;
  logic             hit_ext;
  logic             hit_proc;
  logic             hit_lcfg;
  logic             mapped;
  logic             rd_setup;
  logic             wr_acc;
  logic [2:0]       wlink;
  logic [1:0]       dbg_cfg;
  logic [1:0]       dbg_src;
  logic [31:0]      rd_word;
  logic [7:0][31:0] ext_word;
  logic [3:0][31:0] proc_word;
  logic [7:0][31:0] lcfg_word;
  logic [7:0]       lcfg_sel;

  function automatic logic [31:0] stat_word(input logic [1:0] ty, input logic [7:0] de,
                                            input logic [3:0] di, input logic [1:0] ne,
                                            input logic jk, input logic ro, input logic ri);
    logic [31:0] w;
    w = '0;
    w[sldc_pkg::TYPE_LSB +: sldc_pkg::TYPE_W] = ty;
    w[sldc_pkg::DEST_LSB +: sldc_pkg::DEST_W] = de;
    w[sldc_pkg::DIR_LSB +: sldc_pkg::DIR_W]   = di;
    w[sldc_pkg::NET_LSB +: sldc_pkg::NET_W]   = ne;
    w[sldc_pkg::ST_JUNK_BIT]                  = jk;
    w[sldc_pkg::ST_OUT_BIT]                   = ro;
    w[sldc_pkg::ST_IN_BIT]                    = ri;
    return w;
  endfunction

  // address decode on word index
  assign idx      = paddr_i[sldc_pkg::ADDR_W-1:2];
  assign slot     = idx[sldc_pkg::SLOT_W-1:0];
  assign pslot    = idx[sldc_pkg::PSLOT_W-1:0];
  assign hit_dcfg = idx == sldc_pkg::IDX_DBG_CFG;
  assign hit_dsrc = idx == sldc_pkg::IDX_DBG_SRC;
  assign hit_ext  = idx[sldc_pkg::IDX_W-1:sldc_pkg::SLOT_W]
                    == sldc_pkg::IDX_EXT_STAT[sldc_pkg::IDX_W-1:sldc_pkg::SLOT_W];
  assign hit_proc = idx[sldc_pkg::IDX_W-1:sldc_pkg::PSLOT_W]
                    == sldc_pkg::IDX_PROC_STAT[sldc_pkg::IDX_W-1:sldc_pkg::PSLOT_W];
  assign hit_lcfg = idx[sldc_pkg::IDX_W-1:sldc_pkg::SLOT_W]
                    == sldc_pkg::IDX_LINK_CFG[sldc_pkg::IDX_W-1:sldc_pkg::SLOT_W];
  assign mapped   = (paddr_i[1:0] == 2'h0)
                    && (hit_dcfg || hit_dsrc || hit_ext || hit_proc || hit_lcfg);

  // apb handshake: one setup, one access cycle, never stalled
  assign pready_o  = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign rd_setup  = psel_i && !penable_i && !pwrite_i && mapped;
  assign wr_acc    = psel_i && penable_i && pwrite_i && mapped;

  // strobes to register holders; read clears act with the data capture
  assign bus.wr    = wr_acc;
  assign bus.rd    = rd_setup;
  assign bus.wdata = pwdata_i;

  // slot to link letter map for status and setup words
  assign wlink = sldc_pkg::SLOT_LINK[slot];

  // status words and per-link setup registers
  generate
    for (genvar k = 0; k < sldc_pkg::NUM_EXT; k++)
    begin : g_ext
      localparam int L = int'(sldc_pkg::SLOT_LINK[k]);
      // external word carries direction and network
      assign ext_word[k] = stat_word(ext_route_type_i[L], ext_route_dest_i[L], s_ff.dir[L],
                                     s_ff.ext_net[L], ext_junk_i[L], ext_route_out_i[L],
                                     ext_route_in_i[L]);
      assign lcfg_sel[k] = hit_lcfg && (slot == 3'(k));
      sldc_link_cfg u_link (
        .clock_i          (clock_i),
        .rst_n_i          (rst_n_i),
        .bus              (bus.unit),
        .sel_i            (lcfg_sel[k]),
        .credit_granted_i (link_credit_granted_i[L]),
        .credit_held_i    (link_credit_held_i[L]),
        .error_i          (link_error_i[L]),
        .enable_o         (link_enable_o[L]),
        .wide_o           (link_wide_o[L]),
        .link_greeting_token_o          (link_link_greeting_token_o[L]),
        .rx_reset_o       (link_rx_reset_o[L]),
        .tgap_o           (link_transition_gap_o[L]),
        .kgap_o           (link_token_gap_o[L]),
        .word_o           (lcfg_word[k])
      );
    end
    for (genvar p = 0; p < sldc_pkg::NUM_PROC; p++)
    begin : g_proc
      // processor word has no direction field
      assign proc_word[p] = stat_word(proc_route_type_i[p], proc_route_dest_i[p], 4'h0,
                                      s_ff.proc_net[p], proc_junk_i[p], proc_route_out_i[p],
                                      proc_route_in_i[p]);
    end
  endgenerate

  // debug pin, trap and source record
  sldc_dbg_pin u_dbg (
    .clock_i            (clock_i),
    .rst_n_i            (rst_n_i),
    .bus                (bus.unit),
    .sel_cfg_i          (hit_dcfg),
    .sel_src_i          (hit_dsrc),
    .debug_req_n_i      (debug_req_n_i),
    .core_debug_mode_i  (core_debug_mode_i),
    .tile_debug_event_i (tile_debug_event_i),
    .debug_call_trap_o  (debug_call_trap_o),
    .debug_req_oe_n_o   (debug_req_oe_n_o),
    .cfg_o              (dbg_cfg),
    .src_o              (dbg_src)
  );

  // open-drain debug wire only ever drives low
  assign debug_req_n_o = 1'h0;

  // read mux, reserved and unmapped read zero
  always_comb
  begin
    rd_word = '0;
    if (hit_dcfg)
    begin
      rd_word[sldc_pkg::DBG_TRAP_BIT] = dbg_cfg[1];
      rd_word[sldc_pkg::DBG_PULL_BIT] = dbg_cfg[0];
    end
    else if (hit_dsrc)
    begin
      rd_word[sldc_pkg::SRC_PIN_BIT]  = dbg_src[1];
      rd_word[sldc_pkg::SRC_TILE_BIT] = dbg_src[0];
    end
    else if (hit_ext)
      rd_word = ext_word[slot];
    else if (hit_proc)
      rd_word = proc_word[pslot];
    else if (hit_lcfg)
      rd_word = lcfg_word[slot];
  end

  // data capture and writable routing fields
  always_comb
  begin
    nxt_s = s_ff;
    if (psel_i && !penable_i && !pwrite_i)
      nxt_s.rdata = mapped ? rd_word : '0;
    // direction and network writes, slot mapped to link
    if (wr_acc && hit_ext)
    begin
      nxt_s.dir[wlink]     = pwdata_i[sldc_pkg::DIR_LSB +: sldc_pkg::DIR_W];
      nxt_s.ext_net[wlink] = pwdata_i[sldc_pkg::NET_LSB +: sldc_pkg::NET_W];
    end
    if (wr_acc && hit_proc)
      nxt_s.proc_net[pslot] = pwdata_i[sldc_pkg::NET_LSB +: sldc_pkg::NET_W];
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign prdata_o        = s_ff.rdata;
  assign ext_direction_o = s_ff.dir;
  assign ext_network_o   = s_ff.ext_net;
  assign proc_network_o  = s_ff.proc_net;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_map_c;
    rd_setup && hit_ext && slot == 3'h0 |=> prdata_o[sldc_pkg::ST_IN_BIT] == $past(ext_route_in_i[2])
      && prdata_o[sldc_pkg::ST_JUNK_BIT] == $past(ext_junk_i[2]);
  endproperty
  a_map_c: assert property (p_map_c) else $error("slot 0 not link C");

  property p_type_a;
    rd_setup && hit_ext && slot == 3'h3 |=> prdata_o[25:24] == $past(ext_route_type_i[0])
      && prdata_o[23:16] == $past(ext_route_dest_i[0]);
  endproperty
  a_type_a: assert property (p_type_a) else $error("route type or dest wrong");

  property p_dir_d;
    wr_acc && hit_ext && slot == 3'h1 |=> ext_direction_o[3] == $past(pwdata_i[11:8]);
  endproperty
  a_dir_d: assert property (p_dir_d) else $error("direction write misplaced");

  property p_pnet;
    wr_acc && hit_proc && pslot == 2'h2 |=> proc_network_o[2] == $past(pwdata_i[5:4]) ##1
      $stable(proc_network_o[2]) || $past(wr_acc);
  endproperty
  a_pnet: assert property (p_pnet) else $error("processor network wrong");

  property p_resv;
    rd_setup && hit_dcfg |=> prdata_o[31:2] == 30'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");

  property p_type_g;
    rd_setup && hit_ext && slot == 3'h4
      |=> prdata_o[25:24] == $past(ext_route_type_i[6]);
  endproperty
  a_type_g: assert property (p_type_g) else $error("route type wrong");

  property p_junk_d;
    rd_setup && hit_ext && slot == 3'h1
      |=> prdata_o[2] == $past(ext_junk_i[3]);
  endproperty
  a_junk_d: assert property (p_junk_d) else $error("junk flag wrong");

  property p_out_b;
    rd_setup && hit_ext && slot == 3'h2
      |=> prdata_o[1] == $past(ext_route_out_i[1]);
  endproperty
  a_out_b: assert property (p_out_b) else $error("out route wrong");

  property p_in_h;
    rd_setup && hit_ext && slot == 3'h5
      |=> prdata_o[0] == $past(ext_route_in_i[7]);
  endproperty
  a_in_h: assert property (p_in_h) else $error("in route wrong");

  property p_proc;
    rd_setup && hit_proc
      |=> prdata_o[11:8] == 4'h0 && prdata_o[5:4] == $past(proc_network_o[pslot]);
  endproperty
  a_proc: assert property (p_proc) else $error("processor word wrong");

  property p_en_a;
    wr_acc && hit_lcfg && slot == 3'h3
      |=> link_enable_o[0] == $past(pwdata_i[31]);
  endproperty
  a_en_a: assert property (p_en_a) else $error("link enable misplaced");

  property p_kgap_a;
    wr_acc && hit_lcfg && slot == 3'h3
      |=> link_token_gap_o[0] == $past(pwdata_i[10:0]);
  endproperty
  a_kgap_a: assert property (p_kgap_a) else $error("token gap wrong");

  property p_unmapped;
    psel_i && !penable_i && !pwrite_i && !mapped
      |=> prdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // main scenarios
  c_trap:  cover property (debug_call_trap_o);
  c_link_greeting_token: cover property (link_link_greeting_token_o != 8'h00);
  c_err:   cover property (pslverr_o);
  c_wdir:  cover property (wr_acc && hit_ext);
  c_cred:  cover property (link_credit_held_i != 8'h00);
endmodule
`default_nettype wire

/* hdl/sldc_pkg.sv */
`default_nettype none
package sldc_pkg;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int IDX_W    = 10;
  localparam int NUM_EXT  = 8;
  localparam int NUM_PROC = 4;
  localparam int SLOT_W   = 3;
  localparam int PSLOT_W  = 2;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_DBG_CFG   = 10'h010;
  localparam logic [9:0] IDX_DBG_SRC   = 10'h01F;
  localparam logic [9:0] IDX_EXT_STAT  = 10'h020;
  localparam logic [9:0] IDX_PROC_STAT = 10'h040;
  localparam logic [9:0] IDX_LINK_CFG  = 10'h080;
  // debug fields
  localparam int DBG_PULL_BIT = 0;
  localparam int DBG_TRAP_BIT = 1;
  localparam int SRC_TILE_BIT = 0;
  localparam int SRC_PIN_BIT  = 4;
  // route status fields
  localparam int ST_IN_BIT   = 0;
  localparam int ST_OUT_BIT  = 1;
  localparam int ST_JUNK_BIT = 2;
  localparam int NET_LSB     = 4;
  localparam int NET_W       = 2;
  localparam int DIR_LSB     = 8;
  localparam int DIR_W       = 4;
  localparam int DEST_LSB    = 16;
  localparam int DEST_W      = 8;
  localparam int TYPE_LSB    = 24;
  localparam int TYPE_W      = 2;
  // link setup fields
  localparam int CFG_EN_BIT    = 31;
  localparam int CFG_WIDE_BIT  = 30;
  localparam int CFG_ERR_BIT   = 27;
  localparam int CFG_GRANT_BIT = 26;
  localparam int CFG_HOLD_BIT  = 25;
  localparam int CFG_LINK_GREETING_TOKEN_BIT = 24;
  localparam int CFG_RXRST_BIT = 23;
  localparam int TGAP_LSB      = 11;
  localparam int KGAP_LSB      = 0;
  localparam int GAP_W         = 11;
  // register slot k serves link letter SLOT_LINK[k] (A=0 .. H=7): C D B A G H E F
  localparam logic [7:0][2:0] SLOT_LINK =
    {3'h5, 3'h4, 3'h7, 3'h6, 3'h0, 3'h1, 3'h3, 3'h2};
  typedef enum logic [1:0] {
    SLDC_RT_PROC = 2'h0,
    SLDC_RT_EXT  = 2'h1,
    SLDC_RT_CTRL = 2'h2
  } sldc_route_type;
endpackage
`default_nettype wire

/* hdl/sldc_bus_if.sv */
`timescale 1ns/1ns
`default_nettype none
// register strobes from the bus slave to the register holders
interface sldc_bus_if;
  logic        wr;
  logic        rd;
  logic [31:0] wdata;
  modport host (output wr, output rd, output wdata);
  modport unit (input wr, input rd, input wdata);
endinterface
`default_nettype wire

/* hdl/sldc_dbg_pin.sv */
`timescale 1ns/1ns
`default_nettype none
module sldc_dbg_pin (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  sldc_bus_if.unit        bus,
  input  wire logic       sel_cfg_i,
  input  wire logic       sel_src_i,
  input  wire logic       debug_req_n_i,
  input  wire logic       core_debug_mode_i,
  input  wire logic       tile_debug_event_i,
  output logic            debug_call_trap_o,
  output logic            debug_req_oe_n_o,
  output logic [1:0]      cfg_o,
  output logic [1:0]      src_o
);
  typedef struct packed {
    logic [2:0] sync;   // inverted pin, so reset zero means idle
    logic       lvl;
    logic [1:0] cfg;
    logic       src_pin;
    logic       src_tile;
    logic       trap;
    logic       drive;
  } sldc_dbg_type;
  sldc_dbg_type s_ff, nxt_s;
  logic         rise;

  // pin filter, trap, source record and pin drive
  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.sync = {s_ff.sync[1:0], ~debug_req_n_i};
    rise       = !s_ff.lvl && s_ff.sync[2] && s_ff.sync[1];
    if (s_ff.sync[2] == s_ff.sync[1])
    begin
      nxt_s.lvl = s_ff.sync[2];
    end
    // pin traps only when enabled and not while our own pull-down is driving
    nxt_s.trap = rise && s_ff.cfg[sldc_pkg::DBG_TRAP_BIT] && !s_ff.drive;
    if (bus.wr && sel_cfg_i)
    begin
      nxt_s.cfg = {bus.wdata[sldc_pkg::DBG_TRAP_BIT], bus.wdata[sldc_pkg::DBG_PULL_BIT]};
    end
    if (bus.wr && sel_src_i)
    begin
      nxt_s.src_pin  = bus.wdata[sldc_pkg::SRC_PIN_BIT];
      nxt_s.src_tile = bus.wdata[sldc_pkg::SRC_TILE_BIT];
    end
    // newest event overrides a software write
    if (nxt_s.trap || tile_debug_event_i)
    begin
      nxt_s.src_pin  = nxt_s.trap;
      nxt_s.src_tile = tile_debug_event_i;
    end
    // pull the wire low while in debug mode
    nxt_s.drive = s_ff.cfg[sldc_pkg::DBG_PULL_BIT] && core_debug_mode_i;
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign debug_call_trap_o = s_ff.trap;
  assign debug_req_oe_n_o  = !s_ff.drive;
  assign cfg_o             = s_ff.cfg;
  assign src_o             = {s_ff.src_pin, s_ff.src_tile};

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_trap_en;
    debug_call_trap_o |-> $past(cfg_o[sldc_pkg::DBG_TRAP_BIT]) && $past(debug_req_oe_n_o);
  endproperty
  a_trap_en: assert property (p_trap_en) else $error("trap without enable");
  property p_pull;
    cfg_o[sldc_pkg::DBG_PULL_BIT] && core_debug_mode_i |=> !debug_req_oe_n_o;
  endproperty
  a_pull: assert property (p_pull) else $error("debug wire not pulled");
  property p_src_pin;
    debug_call_trap_o |-> src_o[1];
  endproperty
  a_src_pin: assert property (p_src_pin) else $error("pin source not recorded");
  property p_src_tile;
    tile_debug_event_i |=> src_o[0] && (src_o[1] == debug_call_trap_o);
  endproperty
  a_src_tile: assert property (p_src_tile) else $error("tile source wrong");
endmodule
`default_nettype wire

/* hdl/sldc_link_cfg.sv */
`timescale 1ns/1ns
`default_nettype none
module sldc_link_cfg (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  sldc_bus_if.unit         bus,
  input  wire logic        sel_i,
  input  wire logic        credit_granted_i,
  input  wire logic        credit_held_i,
  input  wire logic        error_i,
  output logic             enable_o,
  output logic             wide_o,
  output logic             link_greeting_token_o,
  output logic             rx_reset_o,
  output logic [10:0]      tgap_o,
  output logic [10:0]      kgap_o,
  output logic [31:0]      word_o
);
  typedef struct packed {
    logic        en;
    logic        wide;
    logic        err;
    logic        link_greeting_token;
    logic        rxrst;
    logic [10:0] tgap;
    logic [10:0] kgap;
  } sldc_link_type;
  sldc_link_type s_ff, nxt_s;
  logic          wr;

  // field writes, self-clearing pulses, sticky error
  always_comb
  begin
    nxt_s       = s_ff;
    wr          = bus.wr && sel_i;
    nxt_s.link_greeting_token = 1'h0;
    nxt_s.rxrst = 1'h0;
    if (wr)
    begin
      nxt_s.en    = bus.wdata[sldc_pkg::CFG_EN_BIT];
      nxt_s.wide  = bus.wdata[sldc_pkg::CFG_WIDE_BIT];
      nxt_s.link_greeting_token = bus.wdata[sldc_pkg::CFG_LINK_GREETING_TOKEN_BIT];
      nxt_s.rxrst = bus.wdata[sldc_pkg::CFG_RXRST_BIT];
      nxt_s.tgap  = bus.wdata[sldc_pkg::TGAP_LSB +: sldc_pkg::GAP_W];
      nxt_s.kgap  = bus.wdata[sldc_pkg::KGAP_LSB +: sldc_pkg::GAP_W];
    end
    // read clears, a new error wins
    nxt_s.err = error_i || (s_ff.err && !(bus.rd && sel_i));
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // read word; credit flags straight from link logic
  always_comb
  begin
    word_o = '0;
    word_o[sldc_pkg::CFG_EN_BIT]    = s_ff.en;
    word_o[sldc_pkg::CFG_WIDE_BIT]  = s_ff.wide;
    word_o[sldc_pkg::CFG_ERR_BIT]   = s_ff.err;
    word_o[sldc_pkg::CFG_GRANT_BIT] = credit_granted_i;
    word_o[sldc_pkg::CFG_HOLD_BIT]  = credit_held_i;
    word_o[sldc_pkg::TGAP_LSB +: sldc_pkg::GAP_W] = s_ff.tgap;
    word_o[sldc_pkg::KGAP_LSB +: sldc_pkg::GAP_W] = s_ff.kgap;
  end

  assign enable_o   = s_ff.en;
  assign wide_o     = s_ff.wide;
  assign link_greeting_token_o    = s_ff.link_greeting_token;
  assign rx_reset_o = s_ff.rxrst;
  assign tgap_o     = s_ff.tgap;
  assign kgap_o     = s_ff.kgap;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_enable;
    wr |=> enable_o == $past(bus.wdata[sldc_pkg::CFG_EN_BIT]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");
  property p_err;
    error_i |=> word_o[sldc_pkg::CFG_ERR_BIT] ##1 (word_o[sldc_pkg::CFG_ERR_BIT] || $past(bus.rd && sel_i));
  endproperty
  a_err: assert property (p_err) else $error("error flag lost");
  property p_link_greeting_token;
    wr && bus.wdata[sldc_pkg::CFG_LINK_GREETING_TOKEN_BIT] |=> link_greeting_token_o ##1 (!link_greeting_token_o || $past(wr));
  endproperty
  a_link_greeting_token: assert property (p_link_greeting_token) else $error("greeting pulse wrong");
  property p_rxrst;
    rx_reset_o |-> $past(wr && bus.wdata[sldc_pkg::CFG_RXRST_BIT]);
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("spurious receiver reset");
endmodule
`default_nettype wire

/* testbench/sldc_remote_end.sv */
`timescale 1ns/1ns
`default_nettype none
// far end of the eight serial links: answers greetings, flags bad symbols
module sldc_remote_end #(
  parameter logic [7:0] REMOTE_WIDE = 8'h00
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] enable_i,
  input  wire logic [7:0] wide_i,
  input  wire logic [7:0] link_greeting_token_i,
  input  wire logic [7:0] bad_i,
  output logic      [7:0] granted_o,
  output logic      [7:0] held_o,
  output logic      [7:0] error_o
);
  logic [7:0][3:0] wait_ff;
  // credit exchange per link, reply lands a few clocks after the greeting
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_ff   <= '0;
      held_o    <= '0;
      granted_o <= '0;
      error_o   <= '0;
    end
    else
    begin
      for (int k = 0; k < 8; k++)
      begin
        if (link_greeting_token_i[k])
        begin
          wait_ff[k]   <= 4'h5;
          held_o[k]    <= 1'b0;
          granted_o[k] <= 1'b0;
        end
        else if (wait_ff[k] == 4'h1)
        begin
          wait_ff[k]   <= 4'h0;
          held_o[k]    <= enable_i[k];
          granted_o[k] <= enable_i[k];
        end
        else if (wait_ff[k] != 4'h0)
          wait_ff[k] <= wait_ff[k] - 4'h1;
        error_o[k] <= bad_i[k] | (enable_i[k] & (wide_i[k] != REMOTE_WIDE[k]));
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  localparam int LMAP [8] = '{2, 3, 1, 0, 6, 7, 4, 5};
  logic             clk, rst_n, psel, penable, pwrite, pready, pslverr, serr;
  logic             pin_low, dwire, dn_o, doe_n, core_dbg, tile_ev, trap;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [7:0][1:0]  rt_type, net_o;
  logic [7:0][7:0]  rt_dest;
  logic [7:0][3:0]  dir_o;
  logic [7:0]       junk, rout, rin, lerr, lgr, lheld, len, lwide, lhello, lrxr, bad;
  logic [3:0][1:0]  p_type, pnet_o;
  logic [3:0][7:0]  p_dest;
  logic [3:0]       p_junk, p_out, p_in;
  logic [7:0][10:0] tgap, kgap;
  int               failures, n_compared, trap_cnt, link_greeting_token_cnt, rxr_cnt;
  sldc_top u_sldc_top (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .debug_req_n_i(dwire), .debug_req_n_o(dn_o),
    .debug_req_oe_n_o(doe_n), .core_debug_mode_i(core_dbg), .tile_debug_event_i(tile_ev),
    .debug_call_trap_o(trap), .ext_route_type_i(rt_type), .ext_route_dest_i(rt_dest),
    .ext_junk_i(junk), .ext_route_out_i(rout), .ext_route_in_i(rin),
    .proc_route_type_i(p_type), .proc_route_dest_i(p_dest), .proc_junk_i(p_junk),
    .proc_route_out_i(p_out), .proc_route_in_i(p_in), .ext_direction_o(dir_o),
    .ext_network_o(net_o), .proc_network_o(pnet_o), .link_error_i(lerr),
    .link_credit_granted_i(lgr), .link_credit_held_i(lheld), .link_enable_o(len),
    .link_wide_o(lwide), .link_link_greeting_token_o(lhello), .link_rx_reset_o(lrxr),
    .link_transition_gap_o(tgap), .link_token_gap_o(kgap));
  sldc_remote_end #(.REMOTE_WIDE(8'h01)) u_sldc_remote_end (.clock_i(clk), .rst_n_i(rst_n),
    .enable_i(len), .wide_i(lwide), .link_greeting_token_i(lhello), .bad_i(bad), .granted_o(lgr),
    .held_o(lheld), .error_o(lerr));
  // open-drain debug wire: outside pull or our own pull-down
  assign dwire = pin_low ? 1'b0 : (doe_n ? 1'b1 : dn_o);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count output pulses
  always @(posedge clk)
  begin
    trap_cnt  += int'(trap === 1'b1);
    link_greeting_token_cnt += int'(lhello[0] === 1'b1);
    rxr_cnt   += int'(lrxr[0] === 1'b1);
  end
  // one bus transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  function automatic logic [31:0] st(input logic [1:0] t, input logic [7:0] d,
                                     input logic j, input logic o, input logic i);
    return {6'h00, t, d, 13'h0000, j, o, i};
  endfunction
  task complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run;
  end
  // test sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, pin_low, core_dbg, tile_ev, bad} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    for (int k = 0; k < 8; k++)
    begin
      rt_type[k] = 2'(k % 3);
      rt_dest[k] = 8'h10 + 8'(k);
    end
    for (int k = 0; k < 4; k++)
    begin
      p_type[k] = 2'((k + 1) % 3);
      p_dest[k] = 8'h20 + 8'(k);
    end
    {junk, rout, rin, p_junk, p_out, p_in} = 36'hA5_3C_0F_9_5_3;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("dbg_cfg", 12'h040, 32'h0);
    rdchk("setup", 12'h20C, 32'h0);
    `CHK("dir", 32'h0, dir_o)
    $display("reset test done");
    apb(1'b1, 12'h040, 32'hFFFF_FFFF);
    rdchk("dbg_cfg", 12'h040, 32'h3);
    apb(1'b1, 12'h040, 32'h2);
    pin_low <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("trap", 1, trap_cnt)
    rdchk("src", 12'h07C, 32'h10);
    pin_low <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b1, 12'h040, 32'h0);
    pin_low <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("trap_off", 1, trap_cnt)
    pin_low <= 1'b0;
    apb(1'b1, 12'h040, 32'h1);
    core_dbg <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("oe_n", 1'b0, doe_n)
    `CHK("dn_o", 1'b0, dn_o)
    core_dbg <= 1'b0;
    tile_ev <= 1'b1;
    @(posedge clk);
    tile_ev <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk("src", 12'h07C, 32'h01);
    apb(1'b1, 12'h07C, 32'hFFFF_FFFF);
    rdchk("src", 12'h07C, 32'h11);
    $display("debug test done");
    for (int s = 0; s < 8; s++)
      rdchk("ext_st", 12'h080 + 12'(4 * s), st(rt_type[LMAP[s]], rt_dest[LMAP[s]],
            junk[LMAP[s]], rout[LMAP[s]], rin[LMAP[s]]));
    apb(1'b1, 12'h08C, 32'hFFFF_FFFF);
    rdchk("ext_rw", 12'h08C, st(rt_type[0], rt_dest[0], junk[0], rout[0], rin[0]) | 32'hF30);
    `CHK("dir_a", 4'hF, dir_o[0])
    `CHK("net_a", 2'h3, net_o[0])
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 12'h100 + 12'(4 * k), 32'hFFFF_FFFF);
      rdchk("proc", 12'h100 + 12'(4 * k), st(p_type[k], p_dest[k], p_junk[k], p_out[k],
            p_in[k]) | 32'h30);
      `CHK("pnet", 2'h3, pnet_o[k])
    end
    $display("status test done");
    apb(1'b1, 12'h20C, 32'hC009_1C56);
    @(posedge clk);
    `CHK("en", 8'h01, len)
    `CHK("wide", 8'h01, lwide)
    `CHK("tgap", 11'h123, tgap[0])
    `CHK("kgap", 11'h456, kgap[0])
    rdchk("setup", 12'h20C, 32'hC009_1C56);
    apb(1'b1, 12'h20C, 32'hC109_1C56);
    repeat (10) @(posedge clk);
    `CHK("link_greeting_token", 1, link_greeting_token_cnt)
    rdchk("credit", 12'h20C, 32'hC609_1C56);
    apb(1'b1, 12'h20C, 32'hC089_1C56);
    repeat (2) @(posedge clk);
    `CHK("rxrst", 1, rxr_cnt)
    bad[0] <= 1'b1;
    @(posedge clk);
    bad[0] <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk("err", 12'h20C, 32'hCE09_1C56);
    rdchk("err_clr", 12'h20C, 32'hC609_1C56);
    apb(1'b1, 12'h20C, 32'h0);
    @(posedge clk);
    `CHK("en_off", 8'h00, len)
    apb(1'b0, 12'h300, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {serr, rd})
    $display("link test done");
    complete_run;
  end
endmodule
`default_nettype wire
